/* File: rtl/ncd_pkg.sv */
// package of constants and types for the nibble cpu register datapath
package ncd_pkg;
  // -----------------------------------------------------------------
  // widths
  // -----------------------------------------------------------------
  localparam int NIB_W = 4;
  localparam int PAGE_PTR_W = 3;
  localparam int STACK_DEPTH = 8;
  localparam int STACK_PTR_W = 3;
  localparam int PC_W = 12;
  localparam int DP_W = 8;
  localparam int ROM_W = 10;
  localparam int IN_PAGE_W = 7;

  // -----------------------------------------------------------------
  // reset values
  // -----------------------------------------------------------------
  localparam logic [2:0] SP_RESET = 3'h7;
  localparam logic [3:0] ACC_RESET = 4'h0;
  localparam logic UPT_RESET = 1'b0;

  // -----------------------------------------------------------------
  // register map, byte addresses
  // -----------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_OPERAND = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_PAIR = 8'h0C;
  localparam logic [7:0] ADDR_RESULT = 8'h10;
  localparam logic [7:0] ADDR_CONTEXT = 8'h14;

  // -----------------------------------------------------------------
  // control register fields
  // -----------------------------------------------------------------
  localparam int CTRL_OP_LSB = 0;
  localparam int CTRL_OP_W = 5;

  // -----------------------------------------------------------------
  // axi responses
  // -----------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // -----------------------------------------------------------------
  // operation codes written to the control register
  // -----------------------------------------------------------------
  typedef enum logic [4:0] {
    OP_NOP = 5'h00,
    OP_ADD_CARRY = 5'h01,
    OP_ADD_IMM = 5'h02,
    OP_ADD_MEM = 5'h03,
    OP_AND_MEM = 5'h04,
    OP_OR_MEM = 5'h05,
    OP_CMP_MEM = 5'h06,
    OP_ROT_RIGHT = 5'h07,
    OP_SET_CARRY = 5'h08,
    OP_CLR_CARRY = 5'h09,
    OP_SET_BIT = 5'h0A,
    OP_CLR_BIT = 5'h0B,
    OP_LOAD_ACC = 5'h0C,
    OP_ACC_TO_AUX = 5'h0D,
    OP_XCH_AUX = 5'h0E,
    OP_AUX_ACC_TO_PAIR = 5'h0F,
    OP_PAIR_TO_AUX_ACC = 5'h10,
    OP_LOAD_PAGE = 5'h11,
    OP_SET_UPPER = 5'h12,
    OP_CLR_UPPER = 5'h13,
    OP_CALL = 5'h14,
    OP_TABLE = 5'h15,
    OP_RETURN = 5'h16,
    OP_INT_ENTRY = 5'h17,
    OP_INT_RETURN = 5'h18,
    OP_SP_TO_ACC = 5'h19
  } ncd_op_t;
endpackage

/* File: rtl/ncd_stack_mem.sv */
// eight entry return address memory with registered read data
`timescale 1ns/1ps
`default_nettype none
module ncd_stack_mem #(
  parameter int DEPTH = 8,
  parameter int AW = 3,
  parameter int DW = 12
) (
  // clock
  input wire logic aclk,
  // write port
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [DW-1:0] wr_data,
  // read port
  input wire logic [AW-1:0] rd_addr,
  output logic [DW-1:0] rd_data
);
  logic [DW-1:0] mem [DEPTH];

  // write, overwriting whatever the slot held
  always_ff @(posedge aclk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // registered read of the addressed slot
  always_ff @(posedge aclk) begin
    rd_data <= mem[rd_addr];
  end
endmodule
`default_nettype wire

/* File: rtl/ncd_alu.sv */
// four bit arithmetic and logic unit
`timescale 1ns/1ps
`default_nettype none
module ncd_alu (
  // operation
  input wire logic [4:0] op,
  input wire logic [3:0] a,
  input wire logic [3:0] b,
  input wire logic [1:0] bit_sel,
  input wire logic cin,
  // results
  output logic [3:0] y,
  output logic cout,
  output logic equal
);
  logic [4:0] sum;

  // add, logic and bit operations on nibbles
  always_comb begin
    sum = {1'b0, a} + {1'b0, b} + ((op == ncd_pkg::OP_ADD_CARRY) ? {4'h0, cin} : 5'h00);
    y = a;
    cout = sum[4];
    equal = (a == b);
    case (op)
      ncd_pkg::OP_ADD_CARRY, ncd_pkg::OP_ADD_IMM, ncd_pkg::OP_ADD_MEM: y = sum[3:0];
      ncd_pkg::OP_AND_MEM: y = a & b;
      ncd_pkg::OP_OR_MEM: y = a | b;
      ncd_pkg::OP_SET_BIT: y = a | (4'h1 << bit_sel);
      ncd_pkg::OP_CLR_BIT: y = a & ~(4'h1 << bit_sel);
      ncd_pkg::OP_ROT_RIGHT: y = {cin, a[3:1]};
      default: y = a;
    endcase
  end
endmodule
`default_nettype wire

/* File: rtl/ncd_datapath.sv */
// register and arithmetic datapath of the nibble cpu, axi4-lite controlled
// Function
// - alu works on 4-bit operands: add, compare, and, or, bit set/clear
// - 4-bit accumulator is operand and result of operations
// - add-with-carry sets carry flag when the sum carries out
// - add-immediate and add-memory leave the carry flag alone
// - rotate right moves accumulator bit 0 into carry
// - set-carry forces carry to one, clear-carry forces it to zero
// - 4-bit auxiliary register for storage and 8-bit transfers
// - 8-bit pair register: auxiliary is upper nibble, accumulator lower
// - pair and page pointer have no reset value; software loads them
// - page pointer and accumulator form the 7-bit in-page address
// - upper-table lookup puts rom bits 9:8 in pointer low bits, clears top
// - lookup with upper-table flag clear leaves page pointer unchanged
// - upper-table flag resets to zero, set and clear by instructions
// - stack saves pc on interrupt, call and table lookup
// - eight identical entries; interrupt and lookup each use one
// - pushing past eight wraps and silently overwrites oldest entries
// - 3-bit stack pointer advances on push, retreats on return
// - stack-pointer-to-accumulator copies the pointer into accumulator
// - interrupt entry saves dp, carry, skip, acc, aux; return restores
// - calls and lookups never touch the interrupt context register
// - stack pointer reads 7 after reset; first call uses entry 0
`timescale 1ns/1ps
`default_nettype none
module ncd_datapath (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // neighbour signals from decoder, pc and interrupt logic
  input wire logic [11:0] pc_in,
  input wire logic [7:0] dp_in,
  input wire logic skip_in,
  input wire logic [9:0] rom_data,
  // neighbour signals to pc and interrupt logic
  output logic [11:0] pc_return,
  output logic pc_return_valid,
  output logic [6:0] in_page_addr,
  output logic [7:0] dp_restore,
  output logic skip_restore,
  output logic restore_valid
);
  // -----------------------------------------------------------------
  // state
  // -----------------------------------------------------------------
  logic [3:0] acc;
  logic [3:0] aux;
  logic [7:0] pair;
  logic [2:0] page_ptr;
  logic carry_flag;
  logic upper_table_flag;
  logic [2:0] stack_level_pointer;
  logic equal_flag;
  logic [7:0] ctx_dp;
  logic ctx_carry;
  logic ctx_skip;
  logic [3:0] ctx_acc;
  logic [3:0] ctx_aux;
  logic [3:0] operand;
  logic [1:0] bit_sel;

  // -----------------------------------------------------------------
  // axi4-lite slave
  // -----------------------------------------------------------------
  logic aw_held;
  logic w_held;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic wr_go;
  logic op_go;
  ncd_pkg::ncd_op_t op;

  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign wr_go = aw_held && w_held;

  // capture address and data in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end else if (wr_go) begin
        aw_held <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end else if (wr_go) begin
        w_held <= 1'b0;
      end
    end
  end

  // write response one cycle after both halves are in
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= ncd_pkg::RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= is_mapped(aw_addr) ? ncd_pkg::RESP_OKAY : ncd_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = (a[7:2] <= ncd_pkg::ADDR_CONTEXT[7:2]);
  endfunction

  assign op_go = wr_go && (aw_addr[7:2] == ncd_pkg::ADDR_CTRL[7:2]) && w_strb[0];
  assign op = ncd_pkg::ncd_op_t'(op_go ? w_data[ncd_pkg::CTRL_OP_LSB +: ncd_pkg::CTRL_OP_W]
                                       : ncd_pkg::OP_NOP);

  // read data from the addressed register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= ncd_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= is_mapped(s_axi_araddr) ? ncd_pkg::RESP_OKAY : ncd_pkg::RESP_SLVERR;
      case (s_axi_araddr[7:2])
        ncd_pkg::ADDR_OPERAND[7:2]: s_axi_rdata <= {26'h0, bit_sel, operand};
        ncd_pkg::ADDR_STATUS[7:2]: s_axi_rdata <= {15'h0, stack_level_pointer,
          page_ptr, equal_flag, upper_table_flag, carry_flag, aux, acc};
        ncd_pkg::ADDR_PAIR[7:2]: s_axi_rdata <= {24'h0, pair};
        ncd_pkg::ADDR_RESULT[7:2]: s_axi_rdata <= {20'h0, pc_return};
        ncd_pkg::ADDR_CONTEXT[7:2]: s_axi_rdata <= {14'h0, ctx_dp, ctx_skip, ctx_carry,
          ctx_aux, ctx_acc};
        default: s_axi_rdata <= 32'h0000_0000;
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // -----------------------------------------------------------------
  // operand register
  // -----------------------------------------------------------------
  // immediate or memory nibble and bit index for the next operation
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      operand <= 4'h0;
      bit_sel <= 2'h0;
    end else if (wr_go && aw_addr[7:2] == ncd_pkg::ADDR_OPERAND[7:2] && w_strb[0]) begin
      operand <= w_data[3:0];
      bit_sel <= w_data[5:4];
    end
  end

  // -----------------------------------------------------------------
  // alu
  // -----------------------------------------------------------------
  logic [3:0] alu_y;
  logic alu_cout;
  logic alu_eq;

  ncd_alu u_alu (
    .op(op),
    .a(acc),
    .b(operand),
    .bit_sel(bit_sel),
    .cin(carry_flag),
    .y(alu_y),
    .cout(alu_cout),
    .equal(alu_eq)
  );

  // -----------------------------------------------------------------
  // accumulator and auxiliary
  // -----------------------------------------------------------------
  // accumulator updates from alu, transfers and context restore
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      acc <= ncd_pkg::ACC_RESET;
    end else begin
      case (op)
        ncd_pkg::OP_ADD_CARRY, ncd_pkg::OP_ADD_IMM, ncd_pkg::OP_ADD_MEM,
        ncd_pkg::OP_AND_MEM, ncd_pkg::OP_OR_MEM, ncd_pkg::OP_SET_BIT,
        ncd_pkg::OP_CLR_BIT, ncd_pkg::OP_ROT_RIGHT: acc <= alu_y;
        ncd_pkg::OP_LOAD_ACC: acc <= operand;
        ncd_pkg::OP_XCH_AUX: acc <= aux;
        ncd_pkg::OP_PAIR_TO_AUX_ACC: acc <= pair[3:0];
        ncd_pkg::OP_SP_TO_ACC: acc <= {1'b0, stack_level_pointer};
        ncd_pkg::OP_INT_RETURN: acc <= ctx_acc;
        default: acc <= acc;
      endcase
    end
  end

  // auxiliary register: temporary storage and pair upper nibble
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aux <= 4'h0;
    end else begin
      case (op)
        ncd_pkg::OP_ACC_TO_AUX, ncd_pkg::OP_XCH_AUX: aux <= acc;
        ncd_pkg::OP_PAIR_TO_AUX_ACC: aux <= pair[7:4];
        ncd_pkg::OP_INT_RETURN: aux <= ctx_aux;
        default: aux <= aux;
      endcase
    end
  end

  // pair register has no reset value by design
  always_ff @(posedge aclk) begin
    if (op == ncd_pkg::OP_AUX_ACC_TO_PAIR) begin
      pair <= {aux, acc};
    end
  end

  // -----------------------------------------------------------------
  // carry and compare flags
  // -----------------------------------------------------------------
  // carry changes only on add-with-carry, rotate, set, clear and interrupt return
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      carry_flag <= 1'b0;
    end else begin
      case (op)
        ncd_pkg::OP_ADD_CARRY: carry_flag <= alu_cout;
        ncd_pkg::OP_ROT_RIGHT: carry_flag <= acc[0];
        ncd_pkg::OP_SET_CARRY: carry_flag <= 1'b1;
        ncd_pkg::OP_CLR_CARRY: carry_flag <= 1'b0;
        ncd_pkg::OP_INT_RETURN: carry_flag <= ctx_carry;
        default: carry_flag <= carry_flag;
      endcase
    end
  end

  // compare result stands until the next compare
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      equal_flag <= 1'b0;
    end else if (op == ncd_pkg::OP_CMP_MEM) begin
      equal_flag <= alu_eq;
    end
  end

  // -----------------------------------------------------------------
  // page pointer and upper-table flag
  // -----------------------------------------------------------------
  // page pointer has no reset value by design
  always_ff @(posedge aclk) begin
    if (op == ncd_pkg::OP_LOAD_PAGE) begin
      page_ptr <= operand[2:0];
    end else if (op == ncd_pkg::OP_TABLE && upper_table_flag) begin
      page_ptr <= {1'b0, rom_data[9:8]};
    end
  end

  assign in_page_addr = {page_ptr, acc};

  // upper-table flag
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      upper_table_flag <= ncd_pkg::UPT_RESET;
    end else if (op == ncd_pkg::OP_SET_UPPER) begin
      upper_table_flag <= 1'b1;
    end else if (op == ncd_pkg::OP_CLR_UPPER) begin
      upper_table_flag <= 1'b0;
    end
  end

  // -----------------------------------------------------------------
  // return address stack
  // -----------------------------------------------------------------
  logic push;
  logic pop;
  logic [2:0] next_sp;
  logic [11:0] stack_rd;

  assign push = (op == ncd_pkg::OP_CALL) || (op == ncd_pkg::OP_TABLE) ||
                (op == ncd_pkg::OP_INT_ENTRY);
  assign pop = (op == ncd_pkg::OP_RETURN) || (op == ncd_pkg::OP_INT_RETURN);
  assign next_sp = stack_level_pointer + 3'h1;

  ncd_stack_mem #(
    .DEPTH(ncd_pkg::STACK_DEPTH),
    .AW(ncd_pkg::STACK_PTR_W),
    .DW(ncd_pkg::PC_W)
  ) u_stack (
    .aclk(aclk),
    .wr_en(push),
    .wr_addr(next_sp),
    .wr_data(pc_in),
    .rd_addr(stack_level_pointer),
    .rd_data(stack_rd)
  );

  // pointer: push advances, return retreats, both modulo eight
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stack_level_pointer <= ncd_pkg::SP_RESET;
    end else if (push) begin
      stack_level_pointer <= next_sp;
    end else if (pop) begin
      stack_level_pointer <= stack_level_pointer - 3'h1;
    end
  end

  // return address appears one cycle after the return
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pc_return_valid <= 1'b0;
      pc_return <= 12'h000;
    end else begin
      pc_return_valid <= 1'b0;
      if (pop) begin
        pc_return <= stack_rd;
        pc_return_valid <= 1'b1;
      end
    end
  end

  // -----------------------------------------------------------------
  // interrupt context register
  // -----------------------------------------------------------------
  // only interrupt entry writes the context
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctx_dp <= 8'h00;
      ctx_carry <= 1'b0;
      ctx_skip <= 1'b0;
      ctx_acc <= 4'h0;
      ctx_aux <= 4'h0;
    end else if (op == ncd_pkg::OP_INT_ENTRY) begin
      ctx_dp <= dp_in;
      ctx_carry <= carry_flag;
      ctx_skip <= skip_in;
      ctx_acc <= acc;
      ctx_aux <= aux;
    end
  end

  // restore strobe for data pointer and skip flag on interrupt return
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      restore_valid <= 1'b0;
      dp_restore <= 8'h00;
      skip_restore <= 1'b0;
    end else begin
      restore_valid <= (op == ncd_pkg::OP_INT_RETURN);
      dp_restore <= ctx_dp;
      skip_restore <= ctx_skip;
    end
  end

  // -----------------------------------------------------------------
  // checks
  // -----------------------------------------------------------------
  property p_carry_add;
    @(posedge aclk) disable iff (!aresetn)
    (op == ncd_pkg::OP_ADD_CARRY) |=> (carry_flag == $past(alu_cout));
  endproperty
  a_carry_add: assert property (p_carry_add) else $error("carry wrong after add");

  property p_carry_keep;
    @(posedge aclk) disable iff (!aresetn)
    (op == ncd_pkg::OP_ADD_IMM || op == ncd_pkg::OP_ADD_MEM) |=> $stable(carry_flag);
  endproperty
  a_carry_keep: assert property (p_carry_keep) else $error("carry moved on plain add");

  property p_rot;
    @(posedge aclk) disable iff (!aresetn)
    (op == ncd_pkg::OP_ROT_RIGHT) |=> (carry_flag == $past(acc[0]));
  endproperty
  a_rot: assert property (p_rot) else $error("rotate carry wrong");

  property p_upper_table;
    @(posedge aclk) disable iff (!aresetn)
    (op == ncd_pkg::OP_TABLE && upper_table_flag) |=>
      (page_ptr == {1'b0, $past(rom_data[9:8])});
  endproperty
  a_upper_table: assert property (p_upper_table) else $error("table page wrong");

  property p_table_keep;
    @(posedge aclk) disable iff (!aresetn)
    (op == ncd_pkg::OP_TABLE && !upper_table_flag) |=> $stable(page_ptr);
  endproperty
  a_table_keep: assert property (p_table_keep) else $error("page moved on table");

  sequence s_push;
    push && !pop;
  endsequence
  property p_push_sp;
    @(posedge aclk) disable iff (!aresetn)
    s_push |=> (stack_level_pointer == $past(stack_level_pointer) + 3'h1);
  endproperty
  a_push_sp: assert property (p_push_sp) else $error("pointer not advanced");

  property p_sp_reset;
    @(posedge aclk) $rose(aresetn) |-> (stack_level_pointer == 3'h7);
  endproperty
  a_sp_reset: assert property (p_sp_reset) else $error("pointer not 7 at reset");

  property p_ctx_only_int;
    @(posedge aclk) disable iff (!aresetn)
    (op == ncd_pkg::OP_CALL || op == ncd_pkg::OP_TABLE) |=> $stable(ctx_acc) && $stable(ctx_dp);
  endproperty
  a_ctx_only_int: assert property (p_ctx_only_int) else $error("context touched");

  sequence s_pop;
    pop && !push;
  endsequence
  property p_ret_pair;
    @(posedge aclk) disable iff (!aresetn)
    s_pop |=> pc_return_valid && (stack_level_pointer == $past(stack_level_pointer) - 3'h1);
  endproperty
  a_ret_pair: assert property (p_ret_pair) else $error("return not popped");

  property p_restore;
    @(posedge aclk) disable iff (!aresetn)
    (op == ncd_pkg::OP_INT_RETURN) |=> restore_valid && (dp_restore == $past(ctx_dp)) &&
      (skip_restore == $past(ctx_skip));
  endproperty
  a_restore: assert property (p_restore) else $error("context not restored");
endmodule
`default_nettype wire

/* File: dv/ncd_nbr_model.sv */
// neighbour model: program counter, data pointer, skip flag, rom word
`timescale 1ns/1ps
`default_nettype none
module ncd_nbr_model (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // bench jump request
  input wire logic [11:0] pc_set,
  input wire logic pc_load,
  // datapath side
  input wire logic [11:0] pc_return,
  input wire logic pc_return_valid,
  output logic [11:0] pc_in,
  output logic [7:0] dp_in,
  output logic skip_in,
  output logic [9:0] rom_data
);
  // program counter: a popped address reloads it, the bench may jump it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pc_in <= 12'h000;
    end else if (pc_return_valid) begin
      pc_in <= pc_return;
    end else if (pc_load) begin
      pc_in <= pc_set;
    end
  end
  // pointer, skip flag and rom word follow the counter
  assign dp_in = pc_in[7:0] ^ 8'h5a;
  assign skip_in = pc_in[0];
  assign rom_data = pc_in[9:0];
endmodule
`default_nettype wire

/* File: dv/testbench.sv */
// self-checking testbench of the nibble cpu register datapath
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam logic [16:0] K = 17'h1_c3ff;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, pc_load, skip_in, skip_restore;
  logic pc_return_valid, restore_valid;
  logic [7:0] awaddr, araddr, dp_in, dp_restore;
  logic [31:0] wdata, rdata, rd;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, rsp;
  logic [11:0] pc_in, pc_return, pc_set;
  logic [9:0] rom_data;
  logic [6:0] in_page_addr;
  int n_fail, checked;
  ncd_datapath ncd_datapath_inst (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .pc_in(pc_in),
    .dp_in(dp_in), .skip_in(skip_in), .rom_data(rom_data), .pc_return(pc_return),
    .pc_return_valid(pc_return_valid), .in_page_addr(in_page_addr),
    .dp_restore(dp_restore), .skip_restore(skip_restore), .restore_valid(restore_valid));
  ncd_nbr_model ncd_nbr_model_inst (.aclk(aclk), .aresetn(aresetn), .pc_set(pc_set),
    .pc_load(pc_load), .pc_return(pc_return), .pc_return_valid(pc_return_valid),
    .pc_in(pc_in), .dp_in(dp_in), .skip_in(skip_in), .rom_data(rom_data));
  // -----------------------------------------------------------------
  // clock, checks and bus tasks
  // -----------------------------------------------------------------
  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // write: address and data offered together, each dropped when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic pa, pw;
    pa = 1'b1;
    pw = 1'b1;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (pa || pw) begin
      @(negedge aclk);
      if (awready) pa = 1'b0;
      if (wready) pw = 1'b0;
      @(posedge aclk);
      awvalid <= pa;
      wvalid <= pw;
    end
    do @(negedge aclk); while (!bvalid);
    rsp = bresp;
    @(posedge aclk);
  endtask
  task automatic rdr(input logic [7:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    do @(negedge aclk); while (!arready);
    @(posedge aclk);
    arvalid <= 1'b0;
    do @(negedge aclk); while (!rvalid);
    rd = rdata;
    rsp = rresp;
    @(posedge aclk);
  endtask
  task automatic op(input ncd_pkg::ncd_op_t c, input logic [5:0] v = 6'h00);
    wr(ncd_pkg::ADDR_OPERAND, {26'h000_0000, v});
    wr(ncd_pkg::ADDR_CTRL, {27'h000_0000, c});
  endtask
  function automatic logic [16:0] f(input logic [2:0] sp, input logic [2:0] pg,
    input logic eq, input logic up, input logic cy, input logic [3:0] aux, input logic [3:0] acc);
    return {sp, pg, eq, up, cy, aux, acc};
  endfunction
  task automatic st(input logic [16:0] e, input logic [16:0] m);
    rdr(ncd_pkg::ADDR_STATUS);
    chk(rd & {15'h0000, m}, {15'h0000, e & m});
  endtask
  task automatic setpc(input logic [11:0] v);
    pc_set <= v;
    pc_load <= 1'b1;
    @(posedge aclk);
    pc_load <= 1'b0;
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // watchdog cuts a hang short
  initial begin
    #40000;
    n_fail++;
    print_verdict();
  end
  // -----------------------------------------------------------------
  // test sequence
  // -----------------------------------------------------------------
  initial begin
    {aresetn, awvalid, wvalid, arvalid, pc_load} = 5'h00;
    {bready, rready, wstrb} = 6'h3f;
    {awaddr, araddr, wdata, pc_set} = 60'h0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    st(f(7, 0, 0, 0, 0, 4'h0, 4'h0), K);
    op(ncd_pkg::OP_LOAD_ACC, 6'h0f);
    op(ncd_pkg::OP_ADD_IMM, 6'h01);
    st(f(7, 0, 0, 0, 0, 4'h0, 4'h0), K);
    op(ncd_pkg::OP_SET_CARRY);
    op(ncd_pkg::OP_ADD_MEM, 6'h03);
    st(f(7, 0, 0, 0, 1, 4'h0, 4'h3), K);
    op(ncd_pkg::OP_CLR_CARRY);
    op(ncd_pkg::OP_LOAD_ACC, 6'h0e);
    op(ncd_pkg::OP_ADD_CARRY, 6'h03);
    st(f(7, 0, 0, 0, 1, 4'h0, 4'h1), K);
    op(ncd_pkg::OP_CLR_CARRY);
    op(ncd_pkg::OP_ROT_RIGHT);
    st(f(7, 0, 0, 0, 1, 4'h0, 4'h0), K);
    $display("test arith done");
    op(ncd_pkg::OP_LOAD_ACC, 6'h0c);
    op(ncd_pkg::OP_AND_MEM, 6'h0a);
    op(ncd_pkg::OP_OR_MEM, 6'h03);
    op(ncd_pkg::OP_CMP_MEM, 6'h0b);
    st(f(7, 0, 1, 0, 1, 4'h0, 4'hb), K | 17'h0_0400);
    op(ncd_pkg::OP_SET_BIT, 6'h20);
    op(ncd_pkg::OP_CLR_BIT, 6'h30);
    st(f(7, 0, 0, 0, 1, 4'h0, 4'h7), K);
    op(ncd_pkg::OP_ACC_TO_AUX);
    op(ncd_pkg::OP_LOAD_ACC, 6'h03);
    op(ncd_pkg::OP_AUX_ACC_TO_PAIR);
    rdr(ncd_pkg::ADDR_PAIR);
    chk(rd, 32'h0000_0073);
    op(ncd_pkg::OP_XCH_AUX);
    st(f(7, 0, 0, 0, 1, 4'h3, 4'h7), K);
    op(ncd_pkg::OP_PAIR_TO_AUX_ACC);
    st(f(7, 0, 0, 0, 1, 4'h7, 4'h3), K);
    $display("test logic and pair done");
    op(ncd_pkg::OP_LOAD_PAGE, 6'h06);
    chk({25'h000_0000, in_page_addr}, 32'h0000_0063);
    setpc(12'h2c5);
    op(ncd_pkg::OP_TABLE);
    st(f(0, 6, 0, 0, 1, 4'h7, 4'h3), K | 17'h0_3800);
    op(ncd_pkg::OP_SET_UPPER);
    op(ncd_pkg::OP_TABLE);
    st(f(1, 2, 0, 1, 1, 4'h7, 4'h3), K | 17'h0_3800);
    op(ncd_pkg::OP_CLR_UPPER);
    op(ncd_pkg::OP_SP_TO_ACC);
    st(f(1, 2, 0, 0, 1, 4'h7, 4'h1), K);
    op(ncd_pkg::OP_RETURN);
    rdr(ncd_pkg::ADDR_RESULT);
    chk(rd, 32'h0000_02c5);
    op(ncd_pkg::OP_RETURN);
    st(f(7, 0, 0, 0, 1, 4'h7, 4'h1), K);
    for (int i = 0; i < 9; i++) begin
      setpc(12'h100 + 12'(i));
      op(ncd_pkg::OP_CALL);
    end
    st(f(0, 0, 0, 0, 1, 4'h7, 4'h1), K);
    op(ncd_pkg::OP_RETURN);
    rdr(ncd_pkg::ADDR_RESULT);
    chk(rd, 32'h0000_0108);
    op(ncd_pkg::OP_RETURN);
    rdr(ncd_pkg::ADDR_RESULT);
    chk(rd, 32'h0000_0107);
    $display("test page and stack done");
    op(ncd_pkg::OP_LOAD_ACC, 6'h05);
    op(ncd_pkg::OP_ACC_TO_AUX);
    op(ncd_pkg::OP_LOAD_ACC, 6'h09);
    setpc(12'h0a7);
    op(ncd_pkg::OP_INT_ENTRY);
    rdr(ncd_pkg::ADDR_CONTEXT);
    chk(rd, {14'h0000, 8'hfd, 1'b1, 1'b1, 4'h5, 4'h9});
    op(ncd_pkg::OP_LOAD_ACC, 6'h00);
    op(ncd_pkg::OP_ACC_TO_AUX);
    op(ncd_pkg::OP_CLR_CARRY);
    op(ncd_pkg::OP_CALL);
    op(ncd_pkg::OP_TABLE);
    rdr(ncd_pkg::ADDR_CONTEXT);
    chk(rd, {14'h0000, 8'hfd, 1'b1, 1'b1, 4'h5, 4'h9});
    op(ncd_pkg::OP_RETURN);
    op(ncd_pkg::OP_RETURN);
    op(ncd_pkg::OP_INT_RETURN);
    st(f(6, 0, 0, 0, 1, 4'h5, 4'h9), K);
    chk({23'h00_0000, skip_restore, dp_restore}, 32'h0000_01fd);
    rdr(ncd_pkg::ADDR_RESULT);
    chk(rd, 32'h0000_00a7);
    $display("test interrupt done");
    rdr(8'h18);
    chk({rsp, rd[29:0]}, {ncd_pkg::RESP_SLVERR, 30'h0000_0000});
    wr(8'h18, 32'h0000_0001);
    chk({30'h0000_0000, rsp}, {30'h0000_0000, ncd_pkg::RESP_SLVERR});
    $display("test bus done");
    print_verdict();
  end
endmodule
`default_nettype wire
